// File: rlc_pkg.sv
// Constants for the regenerator loopback control block
package rlc_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned HOLDOFF_MS = 2000;
  localparam longint unsigned HOLDOFF_CYC = longint'(CLK_HZ) / 1000 * HOLDOFF_MS;
  localparam logic [1:0] OWN_ADDR = 2'h2;
  localparam int unsigned MSG_W = 8;
  localparam int unsigned IND_W = 16;
  localparam logic [MSG_W-1:0] MSG_LOOP_REQ = 8'h50;
  localparam logic [MSG_W-1:0] MSG_RETURN_NORMAL = 8'h01;
  localparam logic [MSG_W-1:0] MSG_HOLD_STATE = 8'h02;
  localparam logic [IND_W-1:0] REG_IND_MASK = 16'h000f;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_IRQ = 4'h8;
  localparam logic [3:0] ADR_MASK = 4'hc;
  localparam int unsigned EV_LOSS = 0;
  localparam int unsigned EV_LOOP_ON = 1;
  localparam int unsigned EV_LOOP_OFF = 2;
  localparam int unsigned EV_PWR = 3;
  localparam int unsigned EV_W = 4;
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_LOOP = 2'b01,
    ST_DOWN = 2'b10
  } rlc_state_type;
endpackage

// File: rlc_regen_loop.sv
// Regenerator loopback controller with Wishbone registers
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module rlc_regen_loop
  import rlc_pkg::*;
#(
  parameter longint unsigned HOLDOFF = HOLDOFF_CYC
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic irq_o, // Interrupt level
  input wire logic up_loss_i, // Upstream LOS/LFA pin
  input wire logic dn_loss_i, // Downstream LOS/LFA pin
  input wire logic up_active_i, // Upstream link active pin
  input wire logic power_source_one_fail_i, // Power source one failed
  input wire logic power_source_two_fail_i, // Power source two failed
  input wire logic msg_valid_i, // Operations message strobe
  input wire logic [1:0] msg_addr_i, // Message address
  input wire logic [MSG_W-1:0] msg_code_i, // Message code
  input wire logic [IND_W-1:0] ind_down_i, // Indicators from line unit
  input wire logic [IND_W-1:0] ind_up_i, // Indicators from network side
  input wire logic [IND_W-1:0] ind_own_i, // Own regenerator indicators
  output logic [IND_W-1:0] ind_up_o, // Indicators toward line unit
  output logic msg_out_valid_o, // Upstream message strobe
  output logic [1:0] msg_out_addr_o, // Upstream message address
  output logic [MSG_W-1:0] msg_out_code_o, // Upstream message code
  output logic msg_fwd_o, // Forward message downstream
  output logic up_enable_o, // Upstream transceiver enable
  output logic dn_enable_o, // Downstream transceiver enable
  output logic up_reset_o, // Upstream transceiver reset pulse
  output logic dn_start_o, // Downstream activation start pulse
  output logic loop_close_o, // Loop switch closed
  output logic fwd_down_o // Forward looped signal downstream
);
  initial begin
    if (HOLDOFF < 1) $error("HOLDOFF must be at least one");
    if (IND_W < 5) $error("Indicator word too narrow for the loop bits");
    if (MSG_W < 2) $error("Message code too narrow");
  end
  ////////////////////////////////////////////////////////////////
  logic [3:0] sync1_q, sync2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {power_source_two_fail_i, power_source_one_fail_i, dn_loss_i, up_loss_i};
      sync2_q <= sync1_q;
    end
  end
  wire loss_s = sync2_q[0] | sync2_q[1];
  wire [1:0] pwr_s = sync2_q[3:2];
  ////////////////////////////////////////////////////////////////
  // Holdoff filters short dropouts before tearing the link down
  logic [63:0] hold_q;
  logic loss_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !loss_s) begin
      hold_q <= 64'h0;
    end else if (hold_q < HOLDOFF) begin
      hold_q <= hold_q + 64'h1;
    end
  end
  wire loss_fire = loss_s && (hold_q == HOLDOFF - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loss_q <= 1'b0;
    end else begin
      loss_q <= loss_s && (hold_q >= HOLDOFF - 1);
    end
  end
  ////////////////////////////////////////////////////////////////
  logic [EV_W-1:0] irq_q, mask_q;
  logic [1:0] ctrl_q;
  rlc_state_type state_q;
  wire own_msg = msg_valid_i && (msg_addr_i == OWN_ADDR);
  wire loop_req = own_msg && (msg_code_i == MSG_LOOP_REQ) && ctrl_q[0];
  wire ret_norm = own_msg && (msg_code_i == MSG_RETURN_NORMAL);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_NORMAL;
    end else if (loss_q) begin
      state_q <= ST_DOWN;
    end else begin
      case (state_q)
        ST_NORMAL: begin
          if (loop_req) state_q <= ST_LOOP;
        end
        ST_LOOP: begin
          if (ret_norm) state_q <= ST_NORMAL;
        end
        ST_DOWN: begin
          if (ctrl_q[1]) state_q <= ST_NORMAL;
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end
  wire in_loop = (state_q == ST_LOOP);
  ////////////////////////////////////////////////////////////////
  // upstream reset on closing
  // Reset lets the far transceiver reconverge under loop conditions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_reset_o <= 1'b0;
    end else begin
      up_reset_o <= (state_q == ST_NORMAL) && loop_req && !loss_q;
    end
  end
  // downstream start pulse
  // Only while upstream is still up, else the restart would be wasted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dn_start_o <= 1'b0;
    end else begin
      dn_start_o <= in_loop && ret_norm && !loss_q && up_active_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_enable_o <= 1'b0;
    end else begin
      up_enable_o <= !loss_q && (state_q != ST_DOWN) && !(in_loop && ret_norm);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dn_enable_o <= 1'b0;
    end else begin
      dn_enable_o <= !loss_q && (state_q != ST_DOWN);
    end
  end
  assign loop_close_o = in_loop;
  assign fwd_down_o = (state_q != ST_DOWN);
  ////////////////////////////////////////////////////////////////
  // message handling during loopback
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msg_out_valid_o <= 1'b0;
      msg_out_addr_o <= 2'h0;
      msg_out_code_o <= '0;
      msg_fwd_o <= 1'b0;
    end else begin
      msg_out_valid_o <= in_loop && msg_valid_i && !own_msg;
      msg_out_addr_o <= OWN_ADDR;
      msg_out_code_o <= MSG_HOLD_STATE;
      msg_fwd_o <= msg_valid_i && !in_loop;
    end
  end
  // selective indicator loop, power bits pass upstream
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_up_o <= '0;
    end else if (in_loop) begin
      ind_up_o <= (ind_down_i & ~REG_IND_MASK) | (ind_own_i & REG_IND_MASK);
    end else begin
      ind_up_o <= (ind_up_i & ~REG_IND_MASK) | (ind_own_i & REG_IND_MASK);
    end
  end
  ////////////////////////////////////////////////////////////////
  logic [1:0] pwr_q;
  // Edge detector idles low, like the failure pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= 2'h0;
    end else begin
      pwr_q <= pwr_s;
    end
  end
  wire [EV_W-1:0] ev;
  assign ev[EV_LOSS] = loss_fire;
  assign ev[EV_LOOP_ON] = (state_q == ST_NORMAL) && loop_req && !loss_q;
  assign ev[EV_LOOP_OFF] = in_loop && ret_norm && !loss_q;
  assign ev[EV_PWR] = |(pwr_s & ~pwr_q);
  wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = acc && wb_we_i && wb_sel_i[0];
  // Set beats clear so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= '0;
    end else if (wr && wb_adr_i == ADR_IRQ) begin
      irq_q <= (irq_q & ~wb_dat_i[EV_W-1:0]) | ev;
    end else begin
      irq_q <= irq_q | ev;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
      ctrl_q <= 2'h1;
    end else begin
      if (wr && wb_adr_i == ADR_MASK) mask_q <= wb_dat_i[EV_W-1:0];
      if (wr && wb_adr_i == ADR_CTRL) ctrl_q <= wb_dat_i[1:0];
      else ctrl_q[1] <= 1'b0;
    end
  end
  assign irq_o = |(irq_q & mask_q);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      // Unmapped addresses read as zero
      if (wb_adr_i == ADR_CTRL) begin
        wb_dat_o <= {31'h0, ctrl_q[0]};
      end else if (wb_adr_i == ADR_STAT) begin
        wb_dat_o <= {26'h0, pwr_s, loss_q, up_active_i, state_q};
      end else if (wb_adr_i == ADR_IRQ) begin
        wb_dat_o <= {28'h0, irq_q};
      end else if (wb_adr_i == ADR_MASK) begin
        wb_dat_o <= {28'h0, mask_q};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Separate run length of the loss input, so the holdoff is timed apart
  logic [63:0] run_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !loss_s) begin
      run_q <= 64'h0;
    end else if (run_q < HOLDOFF) begin
      run_q <= run_q + 64'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_loss_down: assert property (@(posedge clk_i) disable iff (rst_i)
    loss_q |=> !up_enable_o && !dn_enable_o) else $error("link not down on loss");
  a_holdoff_time: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(loss_q) |-> run_q >= HOLDOFF) else $error("loss without holdoff");
  a_loop_close: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[EV_LOOP_ON] |=> in_loop && up_reset_o) else $error("loop not closed");
  a_transparent: assert property (@(posedge clk_i) disable iff (rst_i)
    in_loop |-> fwd_down_o) else $error("loop not transparent");
  a_no_fwd_loop: assert property (@(posedge clk_i) disable iff (rst_i)
    in_loop && msg_valid_i |=> !msg_fwd_o) else $error("message forwarded in loop");
  a_hold_state: assert property (@(posedge clk_i) disable iff (rst_i)
    in_loop && msg_valid_i && msg_addr_i != OWN_ADDR |=> msg_out_valid_o
    && msg_out_code_o == MSG_HOLD_STATE) else $error("no hold state");
  a_ind_loop: assert property (@(posedge clk_i) disable iff (rst_i)
    in_loop && $past(in_loop) |-> ((ind_up_o ^ $past(ind_down_i)) & ~REG_IND_MASK) == '0)
    else $error("indicators not looped");
  a_return: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[EV_LOOP_OFF] |=> !in_loop && !up_enable_o) else $error("return not handled");
  a_dn_start: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[EV_LOOP_OFF] && up_active_i |=> dn_start_o) else $error("no downstream start");
  a_loop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    in_loop && !ret_norm && !loss_q |=> in_loop) else $error("loop dropped");
  // Further checks on loss, gating, pulses and indicator paths
  a_loss_state: assert property (@(posedge clk_i) disable iff (rst_i)
    loss_q |=> state_q == ST_DOWN) else $error("state not down on loss");
  a_down_cut: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_DOWN |-> !fwd_down_o && !loop_close_o) else $error("path not cut");
  a_restart_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_DOWN && !loss_q && ctrl_q[1] |=> state_q == ST_NORMAL) else $error("no restart");
  a_no_early: assert property (@(posedge clk_i) disable iff (rst_i)
    !loss_s |=> !loss_q) else $error("loss without input");
  a_loss_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    loss_fire |=> irq_q[EV_LOSS]) else $error("loss event lost");
  a_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_NORMAL && own_msg && msg_code_i == MSG_LOOP_REQ && !ctrl_q[0] |=> !in_loop)
    else $error("loop closed while disabled");
  a_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    up_reset_o |-> in_loop) else $error("reset pulse outside loop");
  a_reset_once: assert property (@(posedge clk_i) disable iff (rst_i)
    up_reset_o |=> !up_reset_o) else $error("reset pulse too long");
  a_own_no_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    in_loop && own_msg |=> !msg_out_valid_o) else $error("hold state for own address");
  a_hold_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    msg_out_valid_o |-> msg_out_addr_o == OWN_ADDR) else $error("hold state address wrong");
  a_ind_own: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> ((ind_up_o ^ $past(ind_own_i)) & REG_IND_MASK) == '0)
    else $error("own indicators not kept");
  a_ind_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(in_loop) |-> ((ind_up_o ^ $past(ind_up_i)) & ~REG_IND_MASK) == '0)
    else $error("indicators not passed upstream");
  a_dn_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[EV_LOOP_OFF] && !up_active_i |=> !dn_start_o) else $error("start without upstream");
  a_dn_back: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[EV_LOOP_OFF] |=> dn_enable_o) else $error("downstream not enabled");
  ////////////////////////////////////////////////////////////////
  c_loop: cover property (@(posedge clk_i) ev[EV_LOOP_ON]);
  c_hold: cover property (@(posedge clk_i) msg_out_valid_o);
  c_restart: cover property (@(posedge clk_i) state_q == ST_DOWN && ctrl_q[1]);
  c_return: cover property (@(posedge clk_i) ev[EV_LOOP_OFF] && up_active_i);
  c_loss: cover property (@(posedge clk_i) loss_fire);
endmodule

// File: rlc_ltu_model.sv
// Line termination unit model sending operations-channel messages
`timescale 1ns/1ps
module rlc_ltu_model
  import rlc_pkg::*;
(
  input wire logic clk_i, // Bench clock
  output logic msg_valid_o, // Message strobe
  output logic [1:0] msg_addr_o, // Message address
  output logic [MSG_W-1:0] msg_code_o // Message code
);
  initial begin
    msg_valid_o = 1'b0;
    msg_addr_o = 2'h0;
    msg_code_o = 8'h00;
  end
  // one-cycle message
  // Released lines are inverted so a stale value is never mistaken for a message
  task automatic send(input logic [1:0] a, input logic [MSG_W-1:0] c);
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_addr_o <= a;
    msg_code_o <= c;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_addr_o <= ~a;
    msg_code_o <= ~c;
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the regenerator loopback controller
`timescale 1ns/1ps
module tb_top;
  import rlc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, up_loss, up_act, pf1, ack, irq, mv, up_en, dn_en;
  logic up_rst, dn_st, loop, fwd, mo_v, fwd_msg;
  logic [3:0] adr;
  logic [31:0] wdat, rdat;
  logic [1:0] ma, mo_a, fa;
  logic [MSG_W-1:0] mc, mo_c;
  logic [IND_W-1:0] i_dn, i_up, i_own, i_out;
  logic [31:0] exp_q[$];
  int bad_count = 0, cmp_count = 0, n_rst = 0, n_start = 0, n_hold = 0, n_fwd = 0;
  ////////////////////////////////////////////////////////////////////////////
  rlc_regen_loop #(.HOLDOFF(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .up_loss_i(up_loss), .dn_loss_i(1'b0),
    .up_active_i(up_act), .power_source_one_fail_i(pf1), .power_source_two_fail_i(1'b0),
    .msg_valid_i(mv), .msg_addr_i(ma), .msg_code_i(mc), .ind_down_i(i_dn),
    .ind_up_i(i_up), .ind_own_i(i_own), .ind_up_o(i_out), .msg_out_valid_o(mo_v),
    .msg_out_addr_o(mo_a), .msg_out_code_o(mo_c), .msg_fwd_o(fwd_msg),
    .up_enable_o(up_en), .dn_enable_o(dn_en), .up_reset_o(up_rst), .dn_start_o(dn_st),
    .loop_close_o(loop), .fwd_down_o(fwd));
  rlc_ltu_model u_ltu (.clk_i(clk_i), .msg_valid_o(mv), .msg_addr_o(ma), .msg_code_o(mc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Reads note the expected word; the monitor compares it at ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk(rdat, exp_q.pop_front());
    if (up_rst === 1'b1) n_rst++;
    if (dn_st === 1'b1) n_start++;
    if (fwd_msg === 1'b1) n_fwd++;
    if (mo_v === 1'b1) begin
      n_hold++;
      chk({mo_a, mo_c}, {OWN_ADDR, MSG_HOLD_STATE});
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {rst_i, up_act, cyc, stb, we, up_loss, pf1} = 7'b1100000;
    {adr, wdat, i_dn, i_up, i_own} = '0;
    void'($urandom(32'h9800));
    fa = 2'($urandom % 3);
    if (fa == OWN_ADDR) fa = 2'h3;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADR_CTRL, 32'h1);
    wb(0, ADR_STAT, 32'h4);
    wb(1, 4'h2, 32'hffff_ffff);
    wb(0, 4'h2, 32'h0);
    wb(0, ADR_IRQ, 32'h0);
    wb(0, ADR_MASK, 32'h0);
    u_ltu.send(OWN_ADDR, MSG_LOOP_REQ);
    repeat (3) @(posedge clk_i);
    chk({loop, fwd, up_en, dn_en}, 4'hf);
    chk(n_rst, 1);
    wb(0, ADR_STAT, 32'h5);
    u_ltu.send(OWN_ADDR, 8'h33);
    u_ltu.send(fa, MSG_RETURN_NORMAL);
    repeat (3) @(posedge clk_i);
    chk(n_hold, 1);
    chk(loop, 1);
    i_dn <= IND_W'($urandom);
    i_up <= IND_W'($urandom);
    i_own <= IND_W'($urandom);
    repeat (3) @(posedge clk_i);
    chk(i_out, (i_dn & ~REG_IND_MASK) | (i_own & REG_IND_MASK));
    pf1 <= 1'b1;
    u_ltu.send(OWN_ADDR, MSG_RETURN_NORMAL);
    repeat (6) @(posedge clk_i);
    chk(loop, 0);
    chk(n_start, 1);
    chk(i_out, (i_up & ~REG_IND_MASK) | (i_own & REG_IND_MASK));
    // Outside the loop every message goes on downstream, the request included
    u_ltu.send(fa, 8'h33);
    repeat (2) @(posedge clk_i);
    chk(n_fwd, 2);
    chk(n_hold, 1);
    wb(0, ADR_STAT, 32'h14);
    wb(0, ADR_IRQ, 32'he);
    chk(irq, 0);
    wb(1, ADR_MASK, 32'h4);
    @(posedge clk_i);
    chk(irq, 1);
    wb(1, ADR_IRQ, 32'h4);
    @(posedge clk_i);
    chk(irq, 0);
    wb(0, ADR_IRQ, 32'ha);
    // Short holdoff of 20 cycles keeps the loss test brief
    up_loss <= 1'b1;
    repeat (15) @(posedge clk_i);
    chk({up_en, dn_en}, 2'b11);
    repeat (15) @(posedge clk_i);
    chk({up_en, dn_en, fwd}, 3'b000);
    wb(0, ADR_STAT, 32'h1e);
    up_loss <= 1'b0;
    repeat (5) @(posedge clk_i);
    wb(1, ADR_CTRL, 32'h3);
    wb(0, ADR_STAT, 32'h14);
    // Loop enable cleared: a request must be refused
    wb(1, ADR_CTRL, 32'h0);
    u_ltu.send(OWN_ADDR, MSG_LOOP_REQ);
    repeat (3) @(posedge clk_i);
    chk(loop, 0);
    // Reset in mid-run; the standing power failure shows up again as an event
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADR_CTRL, 32'h1);
    wb(0, ADR_STAT, 32'h14);
    wb(0, ADR_IRQ, 32'h8);
    chk(irq, 0);
    report_and_stop();
  end
endmodule
